// File: design/pms_clock_ctrl.sv
/*
 PLL mode and clock output select: strap capture, pre-divider of the
 master clock, reference tick, subsystem clock gating after start-up,
 clock output pin and an AHB-Lite register slave.
 Assumes master clock and straps arrive as asynchronous pins, core_clk
 well above the reference rate, and one AHB-Lite master.
*/
// Design decisions made here: the AHB-Lite slave port and the address map.
`timescale 1ns/100ps
`include "pms_params.svh"

module pms_clock_ctrl #(
   parameter int INIT_CYCLES = `PMS_INIT_CYCLES
) (
   // Clock and reset
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Strap and clock pins
   input  wire logic [2:0]  pll_sel_pins,
   input  wire logic [1:0]  clk_out_sel_pins,
   input  wire logic        crystal_input_pin,
   output logic             clock_output_pin,
   output logic             clockOutputOe,
   // Core side
   output logic             refTick,
   output logic [8:0]       subsysClkOn,
   output logic [11:0]      slotsPerSample,
   output logic [7:0]       coreClockMult,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);

   logic [2:0]  pllSync;
   logic [1:0]  outSelSync;
   logic        xtalSync;

   pms_sync3 #(.WIDTH(3)) u_sync_pll (
      .core_clk (core_clk),
      .rst      (rst),
      .asyncIn  (pll_sel_pins),
      .syncOut  (pllSync)
   );
   pms_sync3 #(.WIDTH(2)) u_sync_out (
      .core_clk (core_clk),
      .rst      (rst),
      .asyncIn  (clk_out_sel_pins),
      .syncOut  (outSelSync)
   );
   pms_sync3 #(.WIDTH(1)) u_sync_xtal (
      .core_clk (core_clk),
      .rst      (rst),
      .asyncIn  (crystal_input_pin),
      .syncOut  (xtalSync)
   );

   // Start-up sequencer and strap capture
   pms_pkg::pms_state_t state_reg, state_next;
   logic [2:0]  settle_reg, settle_next;
   logic [31:0] initCnt_reg, initCnt_next;
   logic [2:0]  pllCode_reg, pllCode_next;
   logic [1:0]  outCode_reg, outCode_next;
   logic        initDone;

   always_comb begin
      state_next   = state_reg;
      settle_next  = settle_reg;
      initCnt_next = initCnt_reg;
      pllCode_next = pllCode_reg;
      outCode_next = outCode_reg;
      case (state_reg)
         pms_pkg::PMS_ST_SETTLE: begin
            settle_next = settle_reg + 3'h1;
            if (settle_reg == `PMS_SYNC_SETTLE) begin
               pllCode_next = pllSync;
               outCode_next = outSelSync;
               state_next   = pms_pkg::PMS_ST_INIT;
            end
         end
         pms_pkg::PMS_ST_INIT: begin
            initCnt_next = initCnt_reg + 32'h0000_0001;
            if (initCnt_reg >= 32'(INIT_CYCLES - 1)) begin
               state_next = pms_pkg::PMS_ST_RUN;
            end
         end
         pms_pkg::PMS_ST_RUN: begin
            state_next = pms_pkg::PMS_ST_RUN;
         end
         default: begin
            state_next = pms_pkg::PMS_ST_SETTLE;
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg   <= pms_pkg::PMS_ST_SETTLE;
         settle_reg  <= 3'h0;
         initCnt_reg <= 32'h0000_0000;
         pllCode_reg <= 3'h0;
         outCode_reg <= 2'h0;
      end else begin
         state_reg   <= state_next;
         settle_reg  <= settle_next;
         initCnt_reg <= initCnt_next;
         pllCode_reg <= pllCode_next;
         outCode_reg <= outCode_next;
      end
   end

   assign initDone = (state_reg == pms_pkg::PMS_ST_RUN);

   // Pre-divider decode
   logic [3:0] preDiv;
   logic       cfgErr;

   always_comb begin
      cfgErr = 1'b0;
      case (pllCode_reg)
         `PMS_PLL_DIV1: preDiv = 4'h1;
         `PMS_PLL_DIV2: preDiv = 4'h2;
         `PMS_PLL_DIV4: preDiv = 4'h4;
         `PMS_PLL_DIV6: preDiv = 4'h6;
         `PMS_PLL_DIV8: preDiv = 4'h8;
         default: begin
            preDiv = 4'h1;
            cfgErr = 1'b1;
         end
      endcase
   end

   // Master clock edges divided to the 64x reference tick; the tick
   // rate times the core multiplier gives the core clock rate
   logic        xtalLast_reg, xtalLast_next;
   logic [3:0]  divCnt_reg, divCnt_next;
   logic        tick_reg, tick_next;
   logic [15:0] perCnt_reg, perCnt_next;
   logic [15:0] period_reg, period_next;
   logic [15:0] phase_reg, phase_next;
   logic        outClk_reg, outClk_next;
   logic [15:0] halfPer;
   logic        xtalRise;

   assign xtalRise = xtalSync & ~xtalLast_reg;
   assign halfPer  = (outCode_reg == `PMS_OUT_X512) ? (period_reg >> 4)
                                                    : (period_reg >> 3);

   always_comb begin
      xtalLast_next = xtalSync;
      divCnt_next   = divCnt_reg;
      tick_next     = 1'b0;
      perCnt_next   = (perCnt_reg == 16'hFFFF) ? perCnt_reg
                                               : perCnt_reg + 16'h0001;
      period_next   = period_reg;
      phase_next    = phase_reg + 16'h0001;
      outClk_next   = outClk_reg;
      if (xtalRise && initDone) begin
         if (divCnt_reg >= preDiv - 4'h1) begin
            divCnt_next = 4'h0;
            tick_next   = 1'b1;
         end else begin
            divCnt_next = divCnt_reg + 4'h1;
         end
      end
      if (tick_reg) begin
         period_next = perCnt_reg;
         perCnt_next = 16'h0001;
         phase_next  = 16'h0001;
         outClk_next = 1'b1;
      end else if (halfPer != 16'h0000 && phase_reg >= halfPer) begin
         phase_next  = 16'h0001;
         outClk_next = ~outClk_reg;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         xtalLast_reg <= 1'b0;
         divCnt_reg   <= 4'h0;
         tick_reg     <= 1'b0;
         perCnt_reg   <= 16'h0000;
         period_reg   <= 16'h0000;
         phase_reg    <= 16'h0000;
         outClk_reg   <= 1'b0;
      end else begin
         xtalLast_reg <= xtalLast_next;
         divCnt_reg   <= divCnt_next;
         tick_reg     <= tick_next;
         perCnt_reg   <= perCnt_next;
         period_reg   <= period_next;
         phase_reg    <= phase_next;
         outClk_reg   <= outClk_next;
      end
   end

   logic overRate;
   assign overRate = (period_reg != 16'h0000) &&
                     (period_reg < 16'(`PMS_REF_MIN_CYC));
   assign refTick  = tick_reg;

   // Clock output pin
   always_comb begin
      case (outCode_reg)
         `PMS_OUT_OFF:  clock_output_pin = 1'b0;
         `PMS_OUT_BUF:  clock_output_pin = xtalSync;
         default:       clock_output_pin = outClk_reg;
      endcase
   end
   assign clockOutputOe = initDone && (outCode_reg != `PMS_OUT_OFF);

   // AHB-Lite register slave, zero wait states
   pms_pkg::pms_ctrl_t ctrl_reg, ctrl_next;
   logic        wrPend_reg, wrPend_next;
   logic [31:0] wrAddr_reg, wrAddr_next;
   logic [31:0] rdata_reg, rdata_next;
   pms_pkg::pms_status_t status;
   logic        take;

   assign take = hsel && htrans[1] && hready;

   always_comb begin
      status           = '0;
      status.initDone  = initDone;
      status.cfgErr    = cfgErr;
      status.overRate  = overRate;
      status.preDiv    = preDiv;
      status.clkOutSel = outCode_reg;
      status.rateSel   = ctrl_reg.rateSel;
      status.slots     = slotsPerSample;
   end

   always_comb begin
      ctrl_next   = ctrl_reg;
      wrPend_next = take && hwrite;
      wrAddr_next = take ? haddr : wrAddr_reg;
      rdata_next  = rdata_reg;
      if (wrPend_reg && initDone &&
          wrAddr_reg == `PMS_OFF_CTRL) begin
         ctrl_next = hwdata[10:0];
      end
      if (take && !hwrite) begin
         case (haddr)
            `PMS_OFF_CTRL:   rdata_next = {21'h0, ctrl_reg};
            `PMS_OFF_STATUS: rdata_next = {4'h0, status};
            `PMS_OFF_PERIOD: rdata_next = {16'h0000, period_reg};
            default:         rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg   <= `PMS_CTRL_RESET;
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 32'h0000_0000;
         rdata_reg  <= 32'h0000_0000;
      end else begin
         ctrl_reg   <= ctrl_next;
         wrPend_reg <= wrPend_next;
         wrAddr_reg <= wrAddr_next;
         rdata_reg  <= rdata_next;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rdata_reg;

   // Subsystem clocks stay blocked until start-up ends
   assign subsysClkOn   = initDone ? ctrl_reg.clkEnReq : 9'h000;
   assign coreClockMult = `PMS_CORE_MULT;
   always_comb begin
      case (ctrl_reg.rateSel)
         `PMS_RATE_DOUBLE: slotsPerSample = `PMS_SLOTS_DOUBLE;
         `PMS_RATE_QUAD:   slotsPerSample = `PMS_SLOTS_QUAD;
         default:          slotsPerSample = `PMS_SLOTS_NORMAL;
      endcase
   end

   // Checks
   a_prediv_decode: assert property (@(posedge core_clk) disable iff (rst)
      pllCode_reg == `PMS_PLL_DIV6 |-> preDiv == 4'h6 && !cfgErr)
      else $error("pre-divider decode wrong");
   a_bad_strap: assert property (@(posedge core_clk) disable iff (rst)
      pllCode_reg[2] && pllCode_reg[1:0] != 2'h0 |-> cfgErr)
      else $error("unsupported strap not flagged");
   a_gate_init: assert property (@(posedge core_clk) disable iff (rst)
      !initDone |-> subsysClkOn == 9'h000 && !refTick)
      else $error("clock passed before start-up end");
   a_strap_hold: assert property (@(posedge core_clk) disable iff (rst)
      state_reg != pms_pkg::PMS_ST_SETTLE |=> $stable(pllCode_reg))
      else $error("strap capture changed after capture");
   a_write_block: assert property (@(posedge core_clk) disable iff (rst)
      wrPend_reg && !initDone |=> $stable(ctrl_reg))
      else $error("write taken during start-up");
   a_slots_rate: assert property (@(posedge core_clk) disable iff (rst)
      ctrl_reg.rateSel == `PMS_RATE_QUAD |-> slotsPerSample == 12'h380)
      else $error("slot count wrong for quad rate");
   a_clock_output_pin_off: assert property (@(posedge core_clk) disable iff (rst)
      outCode_reg == `PMS_OUT_OFF |-> !clock_output_pin && !clockOutputOe)
      else $error("clock output not disabled");
   a_tick_count: assert property (@(posedge core_clk) disable iff (rst)
      pllCode_reg == `PMS_PLL_DIV2 && !cfgErr && tick_reg
      |=> !tick_reg)
      else $error("reference tick longer than one cycle");
   a_over_rate: assert property (@(posedge core_clk) disable iff (rst)
      period_reg == 16'h0003 |-> overRate)
      else $error("overspeed reference not flagged");

   c_run: cover property (@(posedge core_clk) disable iff (rst)
      $rose(initDone));
   c_tick: cover property (@(posedge core_clk) disable iff (rst)
      tick_reg && pllCode_reg == `PMS_PLL_DIV8);
   c_write: cover property (@(posedge core_clk) disable iff (rst)
      wrPend_reg && initDone);
   c_x512: cover property (@(posedge core_clk) disable iff (rst)
      outCode_reg == `PMS_OUT_X512 && $rose(outClk_reg));

endmodule : pms_clock_ctrl

// File: design/pms_params.svh
/*
 Constants for the PLL mode and clock output select block: register
 offsets, field positions, reset values, divider codes and timing counts.
 Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// Register byte offsets
`define PMS_OFF_CTRL        32'h0000_0000
`define PMS_OFF_STATUS      32'h0000_0004
`define PMS_OFF_PERIOD      32'h0000_0008

// Control register fields and reset value
`define PMS_CTRL_EN_LSB     0
`define PMS_CTRL_EN_W       9
`define PMS_CTRL_RATE_LSB   9
`define PMS_CTRL_RESET      11'h000

// Strap codes of the pre-divider
`define PMS_PLL_DIV1        3'h0
`define PMS_PLL_DIV2        3'h1
`define PMS_PLL_DIV4        3'h2
`define PMS_PLL_DIV6        3'h3
`define PMS_PLL_DIV8        3'h4

// Core rate select codes
`define PMS_RATE_NORMAL     2'h0
`define PMS_RATE_DOUBLE     2'h1
`define PMS_RATE_QUAD       2'h2

// Clock output mode codes
`define PMS_OUT_OFF         2'h0
`define PMS_OUT_BUF         2'h1
`define PMS_OUT_X256        2'h2
`define PMS_OUT_X512        2'h3

// Core clock multiplier and instruction slots per sample
`define PMS_CORE_MULT       8'h38
`define PMS_SLOTS_NORMAL    12'hE00
`define PMS_SLOTS_DOUBLE    12'h700
`define PMS_SLOTS_QUAD      12'h380

// Timing
`define PMS_CLK_KHZ         10000
`define PMS_INIT_MS         10
`define PMS_INIT_CYCLES     (`PMS_INIT_MS * `PMS_CLK_KHZ)
`define PMS_SYNC_SETTLE     3'h4
`define PMS_CLK_PERIOD_PS   100000
`define PMS_REF_MIN_PS      325521
`define PMS_REF_MIN_CYC     \
   ((`PMS_REF_MIN_PS + `PMS_CLK_PERIOD_PS - 1) / `PMS_CLK_PERIOD_PS)

`endif

// File: design/pms_pkg.sv
/*
 Types for the PLL mode and clock output select block.
 Assumes pms_params.svh is on the include path.
*/
`include "pms_params.svh"

package pms_pkg;

   typedef enum logic [1:0] {
      PMS_ST_SETTLE,
      PMS_ST_INIT,
      PMS_ST_RUN
   } pms_state_t;

   typedef struct packed {
      logic [1:0] rateSel;
      logic [8:0] clkEnReq;
   } pms_ctrl_t;

   typedef struct packed {
      logic [11:0] slots;
      logic [1:0]  rateSel;
      logic [1:0]  clkOutSel;
      logic [3:0]  preDiv;
      logic [4:0]  zero;
      logic        overRate;
      logic        cfgErr;
      logic        initDone;
   } pms_status_t;

endpackage : pms_pkg

// File: design/pms_sync3.sv
/*
 Three-flop input synchroniser; the output follows once the second and
 third flops agree. Assumes an asynchronous input and core_clk domain.
*/
`timescale 1ns/100ps

module pms_sync3 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // Data
   input  wire logic [WIDTH-1:0] asyncIn,
   output logic      [WIDTH-1:0] syncOut
);

   logic [WIDTH-1:0] ff1_reg;
   logic [WIDTH-1:0] ff2_reg;
   logic [WIDTH-1:0] ff3_reg;
   logic [WIDTH-1:0] out_reg;
   logic [WIDTH-1:0] out_next;

   always_comb begin
      out_next = out_reg;
      if (ff2_reg == ff3_reg) begin
         out_next = ff3_reg;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ff1_reg <= '0;
         ff2_reg <= '0;
         ff3_reg <= '0;
         out_reg <= '0;
      end else begin
         ff1_reg <= asyncIn;
         ff2_reg <= ff1_reg;
         ff3_reg <= ff2_reg;
         out_reg <= out_next;
      end
   end

   assign syncOut = out_reg;

endmodule : pms_sync3

// File: tb/pms_mclk_src.sv
/*
 Board-side model: master clock source on the crystal pin and strap pins.
 Assumes the bench changes slow and strap requests only during reset.
*/
`timescale 1ns/100ps

module pms_mclk_src (
   // Board controls
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic       slow,
   input  wire logic [2:0] strapReq,
   input  wire logic [1:0] modeReq,
   // Pins toward the device
   output logic            crystal_input_pin,
   output logic [2:0]      pll_sel_pins,
   output logic [1:0]      clk_out_sel_pins
);
   // Clock runs from time zero, off the core clock phase, slow enough
   // for the sampler; stopped clock rests low
   initial begin
      crystal_input_pin = 1'b0;
      #37;
      forever begin
         #(slow ? 600 : 300);
         crystal_input_pin = run ? ~crystal_input_pin : 1'b0;
      end
   end

   // Straps only follow requests while reset is held
   always @* begin
      if (rst) begin
         pll_sel_pins     = strapReq;
         clk_out_sel_pins = modeReq;
      end
   end
endmodule : pms_mclk_src

// File: tb/pms_clock_ctrl_tb.sv
/*
 Self-checking bench: every strap code and output mode, register access
 over AHB-Lite, start-up gating and reference period.
 Assumes pms_params.svh and pms_pkg are compiled ahead of it.
*/
`timescale 1ns/100ps

module pms_clock_ctrl_tb;
   localparam int INIT = 20;
   logic          core_clk, rst, run, slow, hsel, hwrite;
   logic [2:0]    strapReq, pllPins;
   logic [1:0]    modeReq, outPins, htrans;
   logic          xtal, clkPin, clkOe, refTick, hreadyout, hresp;
   logic [8:0]    subsysClkOn;
   logic [11:0]   slotsPerSample;
   logic [7:0]    coreClockMult;
   logic [31:0]   haddr, hwdata, hrdata;
   int            mismatches, numChecks;

   pms_mclk_src board (.rst(rst), .run(run), .slow(slow),
      .strapReq(strapReq), .modeReq(modeReq), .crystal_input_pin(xtal),
      .pll_sel_pins(pllPins), .clk_out_sel_pins(outPins));

   pms_clock_ctrl #(.INIT_CYCLES(INIT)) dut (.core_clk(core_clk),
      .rst(rst), .pll_sel_pins(pllPins), .clk_out_sel_pins(outPins),
      .crystal_input_pin(xtal), .clock_output_pin(clkPin),
      .clockOutputOe(clkOe), .refTick(refTick),
      .subsysClkOn(subsysClkOn), .slotsPerSample(slotsPerSample),
      .coreClockMult(coreClockMult), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata));

   initial begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr

   function automatic logic [3:0] expDiv(input logic [2:0] code);
      case (code)
         3'h1: return 4'h2;
         3'h2: return 4'h4;
         3'h3: return 4'h6;
         3'h4: return 4'h8;
         default: return 4'h1;
      endcase
   endfunction : expDiv

   function automatic logic [11:0] expSlots(input logic [1:0] rate);
      case (rate)
         2'h1: return 12'h0700;
         2'h2: return 12'h0380;
         default: return 12'h0E00;
      endcase
   endfunction : expSlots

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic ahbXfer(input logic wr, input logic [31:0] addr,
                          input logic [31:0] wdata, output logic [31:0] rd);
      hsel   <= 1'b1;
      haddr  <= addr;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wdata;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahbXfer

   task automatic tallyAndFinish;
      if (mismatches == 0 && numChecks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tallyAndFinish

   initial begin
      repeat (20000) @(posedge core_clk);
      mismatches++;
      tallyAndFinish();
   end

   initial begin
      logic [31:0]          rnd, d, per;
      logic [10:0]          ctrl;
      logic [3:0]           div;
      pms_pkg::pms_status_t st;
      int                   xe, pe, k, rt;
      logic                 px, pp;
      rst = 1'b1; run = 1'b1; slow = 1'b0; strapReq = 3'h0;
      modeReq = 2'h0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0;
      haddr = 32'h0000_0000; hwdata = 32'h0000_0000;
      mismatches = 0; numChecks = 0; rnd = 32'h0000_76C9;
      for (int i = 0; i < 8; i++) begin
         rnd = lfsr(rnd);
         @(posedge core_clk);
         rst <= 1'b1;
         strapReq <= i[2:0];
         modeReq <= i[1:0];
         slow <= rnd[0];
         repeat (6) @(posedge core_clk);
         chk(hreadyout, 1'b1);
         chk(hresp, 1'b0);
         chk(slotsPerSample, 12'h0E00);
         chk(coreClockMult, 8'h38);
         chk(subsysClkOn, 9'h000);
         chk(clkOe, 1'b0);
         rst <= 1'b0;
         @(posedge core_clk);
         ahbXfer(1'b1, 32'h0000_0000, 32'h0000_07FF, d);
         ahbXfer(1'b0, 32'h0000_0000, 32'h0000_0000, d);
         chk(d, 32'h0000_0000);
         ahbXfer(1'b0, 32'h0000_0004, 32'h0000_0000, d);
         chk(d[0], 1'b0);
         repeat (INIT + 10) @(posedge core_clk);
         chk(subsysClkOn, 9'h000);
         rnd = lfsr(rnd);
         ctrl = rnd[10:0];
         ahbXfer(1'b1, 32'h0000_0000, {21'h0, ctrl}, d);
         ahbXfer(1'b1, 32'h0000_0004, 32'hFFFF_FFFF, d);
         ahbXfer(1'b0, 32'h0000_0000, 32'h0000_0000, d);
         chk(d, {21'h0, ctrl});
         chk(subsysClkOn, ctrl[8:0]);
         chk(slotsPerSample, expSlots(ctrl[10:9]));
         chk(coreClockMult, 8'h38);
         repeat (300) @(posedge core_clk);
         div = expDiv(i[2:0]);
         per = 32'(div) * (slow ? 32'd12 : 32'd6);
         ahbXfer(1'b0, 32'h0000_0008, 32'h0000_0000, d);
         chk(d, per);
         st = '0;
         st.slots = expSlots(ctrl[10:9]);
         st.rateSel = ctrl[10:9];
         st.clkOutSel = i[1:0];
         st.preDiv = div;
         st.cfgErr = (i > 4);
         st.initDone = 1'b1;
         ahbXfer(1'b0, 32'h0000_0004, 32'h0000_0000, d);
         chk(d, {4'h0, st});
         ahbXfer(1'b0, 32'h0000_000C, 32'h0000_0000, d);
         chk(d, 32'h0000_0000);
         xe = 0;
         pe = 0;
         rt = 0;
         px = xtal;
         pp = clkPin;
         repeat (200) begin
            @(posedge core_clk);
            if (xtal !== px) xe++;
            if (clkPin !== pp) pe++;
            if (refTick === 1'b1) rt++;
            px = xtal;
            pp = clkPin;
         end
         chk(clkOe, i[1:0] != 2'h0);
         chk(rt >= 200 / int'(per) - 1 && rt <= 200 / int'(per) + 1, 1'b1);
         k = int'(per) / ((i[1:0] == 2'h2) ? 8 : 16);
         if (i[1:0] == 2'h0)
            chk(32'(pe) + 32'(clkPin), 32'h0);
         else if (i[1:0] == 2'h1)
            chk(pe >= xe - 2 && pe <= xe + 2, 1'b1);
         else if (k > 0)
            chk(pe > 0, 1'b1);
      end
      tallyAndFinish();
   end
endmodule : pms_clock_ctrl_tb
